// file: vpq_cfg.svh
// constants of the vlan priority queue mapper: offsets, field positions, reset values
`ifndef VPQ_CFG_SVH
`define VPQ_CFG_SVH

// register indices; the apb byte address is four times the index
`define VPQ_IDX_MAP_HIGH 8'h81
`define VPQ_IDX_FOLD 8'h82
`define VPQ_IDX_MODE 8'h83
`define VPQ_IDX_STATUS 8'h84
`define VPQ_IDX_CNT_LOW 8'h85
`define VPQ_IDX_CNT_HIGH 8'h86

// field positions in tag_priority_map_high
`define VPQ_TAG7_MSB 7
`define VPQ_TAG7_LSB 6
`define VPQ_TAG6_MSB 5
`define VPQ_TAG6_LSB 4
`define VPQ_TAG5_MSB 3
`define VPQ_TAG5_LSB 2
`define VPQ_TAG4_MSB 1
`define VPQ_TAG4_LSB 0

// reset values: tag seven 3, six 3, five 2, four 2
`define VPQ_MAP_HIGH_RST 8'hfa
`define VPQ_FOLD_RST 2'h0

// status register field positions
`define VPQ_ST_PRIO_LSB 0
`define VPQ_ST_QUEUE_LSB 4
`define VPQ_ST_TAG_LSB 8
`define VPQ_ST_MODE_BIT 12

// frame counter width
`define VPQ_CNT_W 16

// programmable tag fields and possible 2-bit results
`define VPQ_NUM_TAG_FIELDS 4
`define VPQ_NUM_RESULTS 4

`endif

// file: vpq_pkg.sv
// types shared by the vlan priority queue mapper
`include "vpq_cfg.svh"
package vpq_pkg;

    // queue configuration seen by queue selection
    typedef enum logic {
        VPQ_MULTI_QUEUE,
        VPQ_TWO_QUEUE
    } vpq_mode_type;

    // complete state of the mapper
    typedef struct packed {
        logic [7:0] map_high;
        logic [1:0] fold;
        vpq_mode_type mode;
        logic [31:0] prdata;
        logic pslverr;
        logic out_valid;
        logic [1:0] out_prio;
        logic [1:0] out_queue;
        logic [2:0] last_tag;
        logic [`VPQ_CNT_W-1:0] cnt_low;
        logic [`VPQ_CNT_W-1:0] cnt_high;
    } vpq_state_type;

endpackage

// file: vpq_mapper.sv
// vlan priority queue mapper: 802.1p tag to priority result and queue, with apb registers
`timescale 1ns/1ps
`include "vpq_cfg.svh"

module vpq_mapper (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // frame classification side
    input wire logic CLASS_VALID_I,
    input wire logic CLASS_USE_TOS_I,
    input wire logic [2:0] CLASS_TAG_I,
    input wire logic [1:0] CLASS_LOW_MAP_I,
    input wire logic [1:0] CLASS_TOS_RESULT_I,
    // queue selection side
    output logic PRIO_VALID_O,
    output logic [1:0] PRIO_RESULT_O,
    output logic [1:0] QUEUE_SEL_O
);

    // registers reachable over apb; none marks an unmapped address
    typedef enum logic [2:0] {
        VPQ_REG_MAP_HIGH,
        VPQ_REG_FOLD,
        VPQ_REG_MODE,
        VPQ_REG_STATUS,
        VPQ_REG_CNT_LOW,
        VPQ_REG_CNT_HIGH,
        VPQ_REG_NONE
    } vpq_reg_type;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // address decode, used by every register
    function automatic logic is_reg(input logic [11:0] addr, input logic [7:0] idx);
        is_reg = (addr == {2'h0, idx, 2'h0});
    endfunction

    // register selected by an address; anything else is unmapped
    function automatic vpq_reg_type decode_reg(input logic [11:0] addr);
        decode_reg = VPQ_REG_NONE;
        if (is_reg(addr, `VPQ_IDX_MAP_HIGH)) begin
            decode_reg = VPQ_REG_MAP_HIGH;
        end else if (is_reg(addr, `VPQ_IDX_FOLD)) begin
            decode_reg = VPQ_REG_FOLD;
        end else if (is_reg(addr, `VPQ_IDX_MODE)) begin
            decode_reg = VPQ_REG_MODE;
        end else if (is_reg(addr, `VPQ_IDX_STATUS)) begin
            decode_reg = VPQ_REG_STATUS;
        end else if (is_reg(addr, `VPQ_IDX_CNT_LOW)) begin
            decode_reg = VPQ_REG_CNT_LOW;
        end else if (is_reg(addr, `VPQ_IDX_CNT_HIGH)) begin
            decode_reg = VPQ_REG_CNT_HIGH;
        end
    endfunction

    // priority field for tags four to seven
    function automatic logic [1:0] tag_field(input logic [7:0] map, input logic [1:0] sel);
        tag_field = 2'h0;
        unique case (sel)
            2'h3: begin
                tag_field = map[`VPQ_TAG7_MSB:`VPQ_TAG7_LSB];
            end
            2'h2: begin
                tag_field = map[`VPQ_TAG6_MSB:`VPQ_TAG6_LSB];
            end
            2'h1: begin
                tag_field = map[`VPQ_TAG5_MSB:`VPQ_TAG5_LSB];
            end
            2'h0: begin
                tag_field = map[`VPQ_TAG4_MSB:`VPQ_TAG4_LSB];
            end
        endcase
    endfunction

    // two-queue fold: returns one for the high queue
    function automatic logic fold_high(input logic [1:0] result, input logic [1:0] fold);
        fold_high = 1'b0;
        unique case (result)
            2'h0: begin
                fold_high = 1'b0;
            end
            2'h1: begin
                fold_high = fold[0];
            end
            2'h2: begin
                fold_high = fold[1];
            end
            2'h3: begin
                fold_high = 1'b1;
            end
        endcase
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************

    vpq_pkg::vpq_state_type state_r;
    vpq_pkg::vpq_state_type state_nxt;

    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic [1:0] result;
    logic high_q;
    logic [31:0] status_word;
    logic [31:0] read_word;
    vpq_reg_type reg_sel;
    logic wr_map;
    logic wr_fold;
    logic wr_mode;
    logic [1:0] tag_prio [`VPQ_NUM_TAG_FIELDS];
    logic [`VPQ_NUM_RESULTS-1:0] fold_table;

    // ****************************************************************
    // register decode
    // ****************************************************************

    assign setup_phase = PSEL_I & ~PENABLE_I;
    assign access_phase = PSEL_I & PENABLE_I;
    assign reg_sel = decode_reg(PADDR_I);

    // the error latched in setup also blocks the write
    assign wr_access = access_phase & PWRITE_I & ~state_r.pslverr;

    // status and counters are read only: writes to them fall through silently
    assign wr_map = wr_access & (reg_sel == VPQ_REG_MAP_HIGH);
    assign wr_fold = wr_access & (reg_sel == VPQ_REG_FOLD);
    assign wr_mode = wr_access & (reg_sel == VPQ_REG_MODE);

    // ****************************************************************
    // priority mapping
    // ****************************************************************

    // each of tags four to seven reads its own field
    for (genvar g = 0; g < `VPQ_NUM_TAG_FIELDS; g++) begin : g_tag_field
        assign tag_prio[g] = tag_field(state_r.map_high, 2'(g));
    end

    // tags zero to three come from the external low table
    always_comb begin
        result = CLASS_LOW_MAP_I;
        if (CLASS_USE_TOS_I) begin
            result = CLASS_TOS_RESULT_I;
        end else if (CLASS_TAG_I[2]) begin
            // tags four to seven use the programmable fields
            result = tag_prio[CLASS_TAG_I[1:0]];
        end
    end

    // ****************************************************************
    // two-queue fold
    // ****************************************************************

    // all four outcomes stay ready, so the frame path is a single lookup
    // fold any result, tag or tos based
    for (genvar r = 0; r < `VPQ_NUM_RESULTS; r++) begin : g_fold
        assign fold_table[r] = fold_high(2'(r), state_r.fold);
    end

    assign high_q = fold_table[result];

    // ****************************************************************
    // read back
    // ****************************************************************

    // unused bits read zero; an unmapped address reads zero as well
    always_comb begin
        read_word = 32'h0;
        unique case (reg_sel)
            VPQ_REG_MAP_HIGH: begin
                read_word = {24'h0, state_r.map_high};
            end
            VPQ_REG_FOLD: begin
                read_word = {30'h0, state_r.fold};
            end
            VPQ_REG_MODE: begin
                read_word = {31'h0, state_r.mode == vpq_pkg::VPQ_TWO_QUEUE};
            end
            VPQ_REG_STATUS: begin
                read_word = status_word;
            end
            VPQ_REG_CNT_LOW: begin
                read_word = {{(32-`VPQ_CNT_W){1'b0}}, state_r.cnt_low};
            end
            VPQ_REG_CNT_HIGH: begin
                read_word = {{(32-`VPQ_CNT_W){1'b0}}, state_r.cnt_high};
            end
            VPQ_REG_NONE: begin
                read_word = 32'h0;
            end
            // the last code of the three-bit selector is never decoded
            default: begin
                read_word = 32'h0;
            end
        endcase
    end

    // ****************************************************************
    // status word
    // ****************************************************************

    always_comb begin
        status_word = 32'h0;
        status_word[`VPQ_ST_PRIO_LSB +: 2] = state_r.out_prio;
        status_word[`VPQ_ST_QUEUE_LSB +: 2] = state_r.out_queue;
        status_word[`VPQ_ST_TAG_LSB +: 3] = state_r.last_tag;
        status_word[`VPQ_ST_MODE_BIT] = (state_r.mode == vpq_pkg::VPQ_TWO_QUEUE);
    end

    // ****************************************************************
    // next state
    // ****************************************************************

    always_comb begin
        state_nxt = state_r;
        state_nxt.out_valid = CLASS_VALID_I;

        // read data and error are latched in the setup cycle so that
        // the access phase can answer at once from flip-flops
        // a write cycle reads zero, so stale data never follows a write
        if (setup_phase) begin
            state_nxt.pslverr = (reg_sel == VPQ_REG_NONE);
            state_nxt.prdata = PWRITE_I ? 32'h0 : read_word;
        end

        // writes take effect in the access phase only
        if (wr_map) begin
            state_nxt.map_high = PWDATA_I[7:0];
        end
        if (wr_fold) begin
            state_nxt.fold = PWDATA_I[1:0];
        end
        if (wr_mode) begin
            state_nxt.mode = PWDATA_I[0] ? vpq_pkg::VPQ_TWO_QUEUE
                                         : vpq_pkg::VPQ_MULTI_QUEUE;
        end

        // frame path: one cycle from classifier to queue selection
        if (CLASS_VALID_I) begin
            state_nxt.out_prio = result;
            state_nxt.last_tag = CLASS_TAG_I;
            if (state_r.mode == vpq_pkg::VPQ_TWO_QUEUE) begin
                // default fold keeps zero, one and two low
                // full fold keeps only zero low
                state_nxt.out_queue = {1'b0, high_q};
                // counters wrap; software reads deltas
                if (high_q) begin
                    state_nxt.cnt_high = state_r.cnt_high + 1'b1;
                end else begin
                    state_nxt.cnt_low = state_r.cnt_low + 1'b1;
                end
            end else begin
                state_nxt.out_queue = result;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            // tag seven resets to three, tag five to two
            state_r.map_high <= `VPQ_MAP_HIGH_RST;
            state_r.fold <= `VPQ_FOLD_RST;
            state_r.mode <= vpq_pkg::VPQ_MULTI_QUEUE;
            state_r.prdata <= 32'h0;
            state_r.pslverr <= 1'b0;
            state_r.out_valid <= 1'b0;
            state_r.out_prio <= 2'h0;
            state_r.out_queue <= 2'h0;
            state_r.last_tag <= 3'h0;
            state_r.cnt_low <= '0;
            state_r.cnt_high <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // zero wait states: data was prepared during setup
    assign PREADY_O = access_phase;
    assign PSLVERR_O = access_phase & state_r.pslverr;
    assign PRDATA_O = state_r.prdata;
    assign PRIO_VALID_O = state_r.out_valid;
    assign PRIO_RESULT_O = state_r.out_prio;
    assign QUEUE_SEL_O = state_r.out_queue;

endmodule // vpq_mapper

// file: vpq_mapper_properties.sv
// port assertions of the vlan priority queue mapper
`timescale 1ns/1ps
module vpq_mapper_checker (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CLASS_VALID_I,
    input wire logic CLASS_USE_TOS_I,
    input wire logic [1:0] CLASS_TOS_RESULT_I,
    input wire logic PRIO_VALID_O,
    input wire logic [1:0] PRIO_RESULT_O,
    input wire logic [1:0] QUEUE_SEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    property p_valid_next; CLASS_VALID_I |=> PRIO_VALID_O; endproperty
    a_valid_next: assert property (p_valid_next) else $error("no result after frame");
    property p_no_spurious; !CLASS_VALID_I |=> !PRIO_VALID_O; endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("result without frame");
    property p_hold; !CLASS_VALID_I |=> $stable(PRIO_RESULT_O) && $stable(QUEUE_SEL_O); endproperty
    a_hold: assert property (p_hold) else $error("result moved without frame");
    property p_tos;
        CLASS_VALID_I && CLASS_USE_TOS_I |=> PRIO_RESULT_O == $past(CLASS_TOS_RESULT_I);
    endproperty
    a_tos: assert property (p_tos) else $error("tos result not passed");
    property p_zero; PRIO_VALID_O && PRIO_RESULT_O == 2'h0 |-> QUEUE_SEL_O == 2'h0; endproperty
    a_zero: assert property (p_zero) else $error("result zero not in low queue");
    property p_three; PRIO_VALID_O && PRIO_RESULT_O == 2'h3 |-> QUEUE_SEL_O[0]; endproperty
    a_three: assert property (p_three) else $error("result three not high");
    property p_fold; PRIO_VALID_O |-> !QUEUE_SEL_O[1] || QUEUE_SEL_O == PRIO_RESULT_O; endproperty
    a_fold: assert property (p_fold) else $error("queue neither folded nor direct");
    property p_ready; PREADY_O == (PSEL_I && PENABLE_I); endproperty
    a_ready: assert property (p_ready) else $error("ready outside access phase");
    property p_err; PSLVERR_O |-> PREADY_O; endproperty
    a_err: assert property (p_err) else $error("error flag without ready");
endmodule // vpq_mapper_checker

// file: vpq_classifier_model.sv
// frame classifier model driving the mapper's classification side
`timescale 1ns/1ps
module vpq_classifier_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic use_tos_i,
    input wire logic [2:0] tag_i,
    input wire logic [1:0] low_i,
    input wire logic [1:0] tos_i,
    output logic valid_o,
    output logic use_tos_o,
    output logic [2:0] tag_o,
    output logic [1:0] low_o,
    output logic [1:0] tos_o
);
    initial {valid_o, use_tos_o, tag_o, low_o, tos_o} = '0;
    // idle lines flip so a stale value is never mistaken for a frame
    always @(posedge clk_i) begin
        valid_o <= go_i;
        if (go_i) begin
            {use_tos_o, tag_o, low_o, tos_o} <= {use_tos_i, tag_i, low_i, tos_i};
        end else begin
            {use_tos_o, tag_o, low_o, tos_o} <= ~{use_tos_o, tag_o, low_o, tos_o};
        end
    end
endmodule // vpq_classifier_model

// file: testbench.sv
// self-checking bench of the vlan priority queue mapper
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, psel, pen, pwr, go, use_tos, pready, pslverr, err;
    logic c_valid, c_use, p_valid, mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] tag, c_tag;
    logic [1:0] low, tos, c_low, c_tos, p_res, q_sel, fold;
    logic [7:0] map;
    int mismatches, samples_checked;
    int cnt_lo, cnt_hi;
    logic [31:0] last_st;
    vpq_mapper i_vpq_mapper (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CLASS_VALID_I(c_valid),
        .CLASS_USE_TOS_I(c_use), .CLASS_TAG_I(c_tag), .CLASS_LOW_MAP_I(c_low),
        .CLASS_TOS_RESULT_I(c_tos), .PRIO_VALID_O(p_valid), .PRIO_RESULT_O(p_res),
        .QUEUE_SEL_O(q_sel));
    vpq_classifier_model i_vpq_classifier_model (.clk_i(clk), .go_i(go), .use_tos_i(use_tos),
        .tag_i(tag), .low_i(low), .tos_i(tos), .valid_o(c_valid), .use_tos_o(c_use),
        .tag_o(c_tag), .low_o(c_low), .tos_o(c_tos));
    function automatic logic [1:0] exp_prio(logic [2:0] t, logic [1:0] l, logic [1:0] s, logic u);
        if (u) return s;
        if (!t[2]) return l;
        return map[2*t[1:0] +: 2];
    endfunction
    function automatic logic [1:0] exp_queue(logic [1:0] p);
        if (!mode) return p;
        return {1'b0, p == 2'h3 || (p == 2'h1 && fold[0]) || (p == 2'h2 && fold[1])};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d values, %0d wrong", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            complete_run();
        end
    endtask
    task automatic frame(input logic [2:0] t, input logic [1:0] l, input logic [1:0] s, input logic u);
        logic [1:0] ep;
        @(posedge clk);
        go <= 1'b1;
        {tag, low, tos, use_tos} <= {t, l, s, u};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        ep = exp_prio(t, l, s, u);
        chk(p_valid, 1'b1);
        chk(p_res, ep);
        chk(q_sel, exp_queue(ep));
        if (mode) begin
            if (exp_queue(ep) == 2'h1) begin
                cnt_hi++;
            end else begin
                cnt_lo++;
            end
        end
        last_st = {19'h0, mode, 1'b0, t, 2'h0, exp_queue(ep), 2'h0, ep};
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_n, psel, pen, pwr, go, use_tos, paddr, pwdata, tag, low, tos} = '0;
        {map, fold, mode} = {8'hfa, 2'h0, 1'b0};
        last_st = 32'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(32'h4f7e0072));
        apb(1'b0, 12'h204, 32'h0);
        chk(rd, 32'h000000fa);
        apb(1'b0, 12'h208, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, 12'h400, 32'h0);
        chk(err, 1'b1);
        for (int t = 4; t < 8; t++) frame(3'(t), 2'($urandom), 2'($urandom), 1'b0);
        $display("test reset values done");
        apb(1'b1, 12'h20c, 32'h1);
        mode = 1'b1;
        // every fold setting against every result, through the tos path
        for (int f = 0; f < 4; f++) begin
            fold = 2'(f);
            apb(1'b1, 12'h208, 32'(f));
            for (int p = 0; p < 4; p++) frame(3'h0, 2'h0, 2'(p), 1'b1);
        end
        $display("test fold table done");
        for (int i = 0; i < 60; i++) begin
            if (i == 30) begin
                apb(1'b1, 12'h20c, 32'h0);
                mode = 1'b0;
            end
            map = 8'($urandom);
            fold = 2'($urandom);
            apb(1'b1, 12'h204, 32'(map));
            apb(1'b1, 12'h208, 32'(fold));
            apb(1'b0, 12'h204, 32'h0);
            chk(rd, 32'(map));
            frame(3'($urandom), 2'($urandom), 2'($urandom), 1'($urandom));
        end
        $display("test random frames done");
        apb(1'b0, 12'h210, 32'h0);
        chk(rd, last_st);
        apb(1'b0, 12'h214, 32'h0);
        chk(rd, 32'(cnt_lo));
        apb(1'b0, 12'h218, 32'h0);
        chk(rd, 32'(cnt_hi));
        $display("test status and counters done");
        complete_run();
    end
endmodule // testbench
bind vpq_mapper vpq_mapper_checker i_vpq_mapper_checker (.CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .CLASS_VALID_I(CLASS_VALID_I), .CLASS_USE_TOS_I(CLASS_USE_TOS_I),
    .CLASS_TOS_RESULT_I(CLASS_TOS_RESULT_I), .PRIO_VALID_O(PRIO_VALID_O),
    .PRIO_RESULT_O(PRIO_RESULT_O), .QUEUE_SEL_O(QUEUE_SEL_O));
